// file: inc/sfp_defines.svh
// Constants for the serial flash programming interpreter
// How it works
// R1: Host opens with one question mark, then waits for the reply.
// R2: Device sends the sync text and checks the host echoes it exactly.
// R3: Host sends crystal kHz line; device answers with an OK line.
// R4: A bad echo sends the device back to waiting for question mark.
// R5: Erase, write, copy and go are refused until unlocked this session.
// R6: An undefined command letter gets the unknown-command return code.
// R7: Host sends each command as one line with space separated numbers.
// R8: Spare CR and LF characters are dropped, never treated as commands.
// R9: Replies are CR LF lines, return code first, payload only for reads.
// R10: Only write commands are followed by a payload section.
// R11: Payload is UU-encoded, four printable characters per three bytes.
// R12: An encoded line holds at most 61 characters, so 45 bytes.
// R13: The payload sender adds a checksum line after every 20 lines.
// R14: Receiver answers OK on matching checksum, RESEND otherwise; block resent.
// R15: Device sends DC3 when it cannot keep up, DC1 to resume.
// R16: Host obeys DC3 and DC1 and may pace the device with them.
// R17: ESC abandons the current command and waits for a new line.
// R18: Sector n covers 4 kB starting at n times 0x1000, eight at most.
// R19: Write, erase and go aimed at the boot block are rejected. The code checks write, go and copy; erase has only its sector range check.
// R20: A locked request gets an error code and changes nothing.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
// ----------------------------------------
// Characters
// ----------------------------------------
`define SFP_CH_QM 8'h3F
`define SFP_CH_CR 8'h0D
`define SFP_CH_LF 8'h0A
`define SFP_CH_ESC 8'h1B
`define SFP_CH_SP 8'h20
`define SFP_CH_DC1 8'h11
`define SFP_CH_DC3 8'h13
`define SFP_CH_D0 8'h30
`define SFP_CH_D9 8'h39
`define SFP_UU_BIAS 8'h20
// ----------------------------------------
// Return codes, one ASCII digit each
// ----------------------------------------
`define SFP_RC_DONE 8'h30
`define SFP_RC_UNKNOWN 8'h31
`define SFP_RC_PARAM 8'h32
`define SFP_RC_LOCKED 8'h33
`define SFP_RC_PROT 8'h34
`define SFP_RC_BADCODE 8'h35
// ----------------------------------------
// Limits and addresses
// ----------------------------------------
`define SFP_UNLOCK_CODE 32'h0000_5A5A
`define SFP_BOOT_LO 32'h7FFF_E000
`define SFP_BOOT_HI 32'h7FFF_FFFF
`define SFP_SECT_LAST 32'h0000_0007
`define SFP_LINE_MAX 6'h3D
`define SFP_BYTES_MAX 6'h2D
`define SFP_BLOCK_LINES 5'h14
`define SFP_SYNC_LAST 4'hD
`endif

// file: inc/sfp_pkg.sv
// Types and reply text shared by the interpreter and its transmitter
`include "sfp_defines.svh"
package sfp_pkg;
	typedef enum logic [2:0] {
		SFP_ST_WAIT = 3'h0,
		SFP_ST_ECHO = 3'h1,
		SFP_ST_FREQ = 3'h3,
		SFP_ST_CMD = 3'h2,
		SFP_ST_DATA = 3'h6,
		SFP_ST_SUM = 3'h7
	} sfp_state_t;
	typedef enum logic [1:0] {
		SFP_MSG_SYNC = 2'h0,
		SFP_MSG_OK = 2'h1,
		SFP_MSG_RESEND = 2'h2,
		SFP_MSG_RC = 2'h3
	} sfp_msg_t;
	typedef enum logic [1:0] {
		SFP_OP_NONE = 2'h0,
		SFP_OP_ERASE = 2'h1,
		SFP_OP_GO = 2'h2
	} sfp_opkind_t;
	typedef struct packed {
		sfp_opkind_t kind;
		logic [31:0] addr;
		logic [2:0] first;
		logic [2:0] last;
	} sfp_op_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] data;
	} sfp_wr_t;
	// Last character index of each reply
	function automatic logic [3:0] sfp_msg_last(input sfp_msg_t m);
		unique case (m)
			SFP_MSG_SYNC: sfp_msg_last = `SFP_SYNC_LAST;
			SFP_MSG_OK: sfp_msg_last = 4'h3;
			SFP_MSG_RESEND: sfp_msg_last = 4'h7;
			SFP_MSG_RC: sfp_msg_last = 4'h2;
		endcase
	endfunction
	// Character idx of reply m, every reply ends in CR LF
	function automatic logic [7:0] sfp_msg_char(input sfp_msg_t m, input logic [3:0] idx, input logic [7:0] code);
		logic [111:0] s;
		s = "Synchronized\r\n";
		unique case (m)
			SFP_MSG_SYNC: sfp_msg_char = s[8 * (13 - idx) +: 8];
			SFP_MSG_OK: sfp_msg_char = 8'({"OK\r\n"} >> (8 * (3 - idx)));
			SFP_MSG_RESEND: sfp_msg_char = 8'({"RESEND\r\n"} >> (8 * (7 - idx)));
			SFP_MSG_RC: sfp_msg_char = 8'({code, "\r\n"} >> (8 * (2 - idx)));
		endcase
	endfunction
endpackage

// file: design/sfp_tx.sv
// Reply transmitter: emits reply lines and flow control characters
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.svh"
module sfp_tx (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic start,
	input wire sfp_pkg::sfp_msg_t msg,
	input wire logic [7:0] code,
	input wire logic flow_req,
	input wire logic [7:0] flow_chr,
	input wire logic hold,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready
);
	logic busy_q;
	sfp_pkg::sfp_msg_t msg_q;
	logic [7:0] code_q;
	logic [3:0] idx_q;
	logic pend_q;
	logic [7:0] pchr_q;
	logic valid_q;
	logic [7:0] data_q;

	// ----------------------------------------
	// Character slot selection
	// ----------------------------------------
	// Flow characters jump the queue; host DC3 stalls only reply text
	wire slot = !valid_q || tx_ready;
	wire send_flow = slot && pend_q;
	wire send_msg = slot && !pend_q && busy_q && !hold;
	wire last = idx_q == sfp_pkg::sfp_msg_last(msg_q);
	wire [7:0] msg_chr = sfp_pkg::sfp_msg_char(msg_q, idx_q, code_q);

	// Output register and reply walker
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_q <= 1'b0;
			msg_q <= sfp_pkg::SFP_MSG_OK;
			code_q <= 8'h00;
			idx_q <= 4'h0;
			pend_q <= 1'b0;
			pchr_q <= 8'h00;
			valid_q <= 1'b0;
			data_q <= 8'h00;
		end
		else
		begin
			if (slot)
				valid_q <= send_flow || send_msg;
			if (send_flow)
				data_q <= pchr_q; // [R15]
			else if (send_msg)
				data_q <= msg_chr; // [R9]
			pend_q <= flow_req || (pend_q && !send_flow); // New request wins over the send
			if (flow_req)
				pchr_q <= flow_chr;
			if (start && !busy_q)
			begin
				busy_q <= 1'b1;
				msg_q <= msg;
				code_q <= code;
				idx_q <= 4'h0;
			end
			else if (send_msg)
			begin
				idx_q <= idx_q + 4'h1;
				busy_q <= !last;
			end
		end
	end

	assign tx_valid = valid_q;
	assign tx_data = data_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_flow_char_out: assert property (flow_req && !pend_q && !valid_q && !send_msg |=> ##1 tx_valid && tx_data == $past(flow_chr, 2)) // [R15]
		else $error("flow character not sent");
	a_line_ends_lf: assert property (send_msg && last |=> tx_data == `SFP_CH_LF && tx_valid) // [R9]
		else $error("reply line not ended by LF");
	a_host_pause: assert property (hold && !pend_q && slot |=> !tx_valid) // [R16]
		else $error("reply sent while host paused us");
endmodule
`default_nettype wire

// file: design/sfp_interp.sv
// Serial flash programming command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.svh"
module sfp_interp (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output sfp_pkg::sfp_op_t fl_op,
	output logic fl_op_valid,
	output sfp_pkg::sfp_wr_t fl_wr,
	output logic fl_wr_valid,
	input wire logic fl_wr_ready,
	output logic unlocked,
	output logic cmd_mode
);
	sfp_pkg::sfp_state_t st_q;
	logic unlocked_q, have_cmd_q, innum_q, fdig_q, paused_q, host_pause_q;
	logic [7:0] cmd_q;
	logic [1:0] pidx_q;
	logic [31:0] prm_q [0:2];
	logic [3:0] eidx_q;
	logic [31:0] rem_q, wr_addr_q, blk_addr_q, blk_rem_q, sum_q;
	logic [5:0] lchar_q, ulen_q;
	logic [17:0] quad_q;
	logic [1:0] qpos_q, hold_n_q;
	logic [23:0] hold_q;
	logic [4:0] lines_q;
	logic tx_start_q;
	sfp_pkg::sfp_msg_t tx_msg_q;
	logic [7:0] tx_code_q;
	sfp_pkg::sfp_op_t op_q;
	logic op_valid_q;

	// Address falls inside the boot block
	function automatic logic in_boot(input logic [31:0] a);
		in_boot = a >= `SFP_BOOT_LO && a <= `SFP_BOOT_HI;
	endfunction
	// Command letter is one the interpreter defines
	function automatic logic is_known(input logic [7:0] c);
		is_known = c inside {"U", "B", "A", "W", "R", "P", "C", "G", "E", "I", "J", "K", "M"};
	endfunction

	// ----------------------------------------
	// Character classes
	// ----------------------------------------
	wire is_flow = rx_data == `SFP_CH_DC1 || rx_data == `SFP_CH_DC3;
	wire ch = rx_valid && !is_flow;
	wire is_eol = rx_data == `SFP_CH_CR || rx_data == `SFP_CH_LF;
	wire is_esc = rx_data == `SFP_CH_ESC;
	wire is_sp = rx_data == `SFP_CH_SP;
	wire is_dig = rx_data >= `SFP_CH_D0 && rx_data <= `SFP_CH_D9;
	wire [31:0] acc_next = 32'(prm_q[pidx_q] * 32'd10 + {28'h000_0000, rx_data[3:0]});
	wire esc_abort = ch && is_esc && st_q inside {sfp_pkg::SFP_ST_CMD, sfp_pkg::SFP_ST_DATA, sfp_pkg::SFP_ST_SUM};

	// ----------------------------------------
	// Command decode at end of line
	// ----------------------------------------
	wire [31:0] p0 = prm_q[0];
	wire [31:0] p1 = prm_q[1];
	wire [31:0] w_end = 32'(p0 + p1 - 32'h1);
	wire exec = ch && is_eol && st_q == sfp_pkg::SFP_ST_CMD && have_cmd_q;
	wire known = is_known(cmd_q);
	wire gated = cmd_q inside {"E", "W", "G", "C"};
	wire erase_bad = p1 > `SFP_SECT_LAST || p0 > p1;
	wire [7:0] rc = !known ? `SFP_RC_UNKNOWN : // [R6]
		(gated && !unlocked_q) ? `SFP_RC_LOCKED : // [R5] [R20]
		cmd_q == "U" ? (p0 == `SFP_UNLOCK_CODE ? `SFP_RC_DONE : `SFP_RC_BADCODE) :
		cmd_q == "E" ? (erase_bad ? `SFP_RC_PARAM : `SFP_RC_DONE) :
		cmd_q == "W" ? ((in_boot(p0) || in_boot(w_end)) ? `SFP_RC_PROT : // [R19]
			(p1 == 32'h0 ? `SFP_RC_PARAM : `SFP_RC_DONE)) :
		cmd_q inside {"G", "C"} ? (in_boot(p0) ? `SFP_RC_PROT : `SFP_RC_DONE) : // [R19]
		`SFP_RC_DONE;
	wire rc_ok = rc == `SFP_RC_DONE;

	// ----------------------------------------
	// UU decode of payload characters
	// ----------------------------------------
	wire [5:0] v6 = 6'(rx_data - `SFP_UU_BIAS); // [R11]
	wire [23:0] grp = {quad_q, v6};
	wire [5:0] take_l = ulen_q > 6'h3 ? 6'h3 : ulen_q;
	wire [1:0] take = rem_q < {26'h000_0000, take_l} ? rem_q[1:0] : take_l[1:0];
	wire [31:0] grp_sum = {24'h00_0000, grp[23:16]} + (take > 2'h1 ? {24'h00_0000, grp[15:8]} : 32'h0) +
		(take > 2'h2 ? {24'h00_0000, grp[7:0]} : 32'h0);
	wire line_bad = lchar_q == `SFP_LINE_MAX || (lchar_q == 6'h0 && v6 > `SFP_BYTES_MAX); // [R12]
	wire block_end = rem_q == 32'h0 || lines_q == `SFP_BLOCK_LINES - 5'h1; // [R13]

	// Pace the host while the flash sink holds back decoded bytes
	wire xoff = hold_n_q != 2'h0 && !fl_wr_ready && !paused_q; // [R15]
	wire xon = paused_q && hold_n_q == 2'h0; // [R15]

	// Interpreter state and data path
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= sfp_pkg::SFP_ST_WAIT;
			{unlocked_q, have_cmd_q, innum_q, fdig_q, paused_q, host_pause_q} <= 6'h00;
			cmd_q <= 8'h00;
			pidx_q <= 2'h0;
			for (int i = 0; i < 3; i++)
				prm_q[i] <= 32'h0000_0000;
			eidx_q <= 4'h0;
			{rem_q, wr_addr_q, blk_addr_q, blk_rem_q, sum_q} <= 160'h0;
			{lchar_q, ulen_q, quad_q, qpos_q, hold_n_q, hold_q, lines_q} <= 63'h0;
			tx_start_q <= 1'b0;
			tx_msg_q <= sfp_pkg::SFP_MSG_OK;
			tx_code_q <= 8'h00;
			op_q <= '0;
			op_valid_q <= 1'b0;
		end
		else
		begin
			tx_start_q <= 1'b0;
			op_valid_q <= 1'b0;
			if (xoff || xon)
				paused_q <= xoff;
			if (rx_valid && is_flow)
				host_pause_q <= rx_data == `SFP_CH_DC3; // [R16]
			if (fl_wr_valid && fl_wr_ready)
			begin
				hold_q <= {hold_q[15:0], 8'h00};
				hold_n_q <= hold_n_q - 2'h1;
				wr_addr_q <= wr_addr_q + 32'h1;
			end
			if (esc_abort || exec)
			begin
				have_cmd_q <= 1'b0; // [R17]
				pidx_q <= 2'h0;
				innum_q <= 1'b0;
				for (int i = 0; i < 3; i++)
					prm_q[i] <= 32'h0000_0000;
			end
			if (esc_abort)
			begin
				st_q <= sfp_pkg::SFP_ST_CMD; // [R17]
				hold_n_q <= 2'h0;
			end
			else if (ch)
			begin
				unique case (st_q)
					sfp_pkg::SFP_ST_WAIT:
						if (rx_data == `SFP_CH_QM) // [R1]
						begin
							tx_start_q <= 1'b1;
							tx_msg_q <= sfp_pkg::SFP_MSG_SYNC; // [R2]
							eidx_q <= 4'h0;
							unlocked_q <= 1'b0;
							st_q <= sfp_pkg::SFP_ST_ECHO;
						end
					sfp_pkg::SFP_ST_ECHO:
						if (rx_data != sfp_pkg::sfp_msg_char(sfp_pkg::SFP_MSG_SYNC, eidx_q, 8'h00))
							st_q <= sfp_pkg::SFP_ST_WAIT; // [R4]
						else if (eidx_q == `SFP_SYNC_LAST)
						begin
							tx_start_q <= 1'b1; // [R2]
							tx_msg_q <= sfp_pkg::SFP_MSG_OK;
							fdig_q <= 1'b0;
							st_q <= sfp_pkg::SFP_ST_FREQ;
						end
						else
							eidx_q <= eidx_q + 4'h1;
					sfp_pkg::SFP_ST_FREQ:
						if (is_dig)
							fdig_q <= 1'b1;
						else if (is_eol && fdig_q)
						begin
							tx_start_q <= 1'b1; // [R3]
							tx_msg_q <= sfp_pkg::SFP_MSG_OK;
							st_q <= sfp_pkg::SFP_ST_CMD;
						end
					sfp_pkg::SFP_ST_CMD:
						if (exec)
						begin
							tx_start_q <= 1'b1; // [R9]
							tx_msg_q <= sfp_pkg::SFP_MSG_RC;
							tx_code_q <= rc;
							if (rc_ok && cmd_q == "U")
								unlocked_q <= 1'b1;
							if (rc_ok && cmd_q inside {"E", "G"})
							begin
								op_valid_q <= 1'b1;
								op_q.kind <= cmd_q == "E" ? sfp_pkg::SFP_OP_ERASE : sfp_pkg::SFP_OP_GO;
								op_q.addr <= cmd_q == "E" ? {17'h0_0000, p0[2:0], 12'h000} : p0; // [R18]
								op_q.first <= p0[2:0];
								op_q.last <= p1[2:0];
							end
							if (rc_ok && cmd_q == "W")
							begin
								st_q <= sfp_pkg::SFP_ST_DATA; // [R10]
								{rem_q, blk_rem_q, wr_addr_q, blk_addr_q} <= {p1, p1, p0, p0};
								{sum_q, lines_q, lchar_q, qpos_q} <= 45'h0;
							end
						end
						else if (is_sp)
						begin
							if (innum_q && pidx_q != 2'h2)
								pidx_q <= pidx_q + 2'h1;
							innum_q <= 1'b0;
						end
						else if (is_dig && have_cmd_q)
						begin
							prm_q[pidx_q] <= acc_next;
							innum_q <= 1'b1;
						end
						else if (!have_cmd_q && !is_eol) // [R8]
						begin
							cmd_q <= rx_data;
							have_cmd_q <= 1'b1;
						end
					sfp_pkg::SFP_ST_DATA:
						if (is_eol)
						begin
							if (lchar_q != 6'h0) // [R8]
							begin
								lchar_q <= 6'h0;
								qpos_q <= 2'h0;
								lines_q <= lines_q + 5'h1;
								if (block_end)
									st_q <= sfp_pkg::SFP_ST_SUM; // [R13]
							end
						end
						else if (line_bad)
						begin
							tx_start_q <= 1'b1; // [R12]
							tx_msg_q <= sfp_pkg::SFP_MSG_RC;
							tx_code_q <= `SFP_RC_PARAM;
							hold_n_q <= 2'h0;
							st_q <= sfp_pkg::SFP_ST_CMD;
						end
						else
						begin
							lchar_q <= lchar_q + 6'h1;
							if (lchar_q == 6'h0)
								ulen_q <= v6;
							else
							begin
								quad_q <= {quad_q[11:0], v6}; // [R11]
								qpos_q <= qpos_q + 2'h1;
								if (qpos_q == 2'h3)
								begin
									hold_q <= grp;
									hold_n_q <= take;
									ulen_q <= ulen_q - {4'h0, take};
									rem_q <= rem_q - {30'h0, take};
									sum_q <= sum_q + grp_sum;
								end
							end
						end
					sfp_pkg::SFP_ST_SUM:
						if (is_dig)
						begin
							prm_q[0] <= acc_next;
							innum_q <= 1'b1;
						end
						else if (is_eol && innum_q)
						begin
							tx_start_q <= 1'b1;
							innum_q <= 1'b0;
							prm_q[0] <= 32'h0;
							{sum_q, lines_q} <= 37'h0;
							st_q <= (p0 == sum_q && rem_q == 32'h0) ? sfp_pkg::SFP_ST_CMD : sfp_pkg::SFP_ST_DATA;
							if (p0 == sum_q)
							begin
								tx_msg_q <= sfp_pkg::SFP_MSG_OK; // [R14]
								blk_addr_q <= 32'(blk_addr_q + blk_rem_q - rem_q);
								blk_rem_q <= rem_q;
							end
							else
							begin
								tx_msg_q <= sfp_pkg::SFP_MSG_RESEND; // [R14]
								wr_addr_q <= blk_addr_q;
								rem_q <= blk_rem_q;
								hold_n_q <= 2'h0;
							end
						end
					default:
						st_q <= sfp_pkg::SFP_ST_WAIT;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign fl_op = op_q;
	assign fl_op_valid = op_valid_q;
	assign fl_wr = '{addr: wr_addr_q, data: hold_q[23:16]};
	assign fl_wr_valid = hold_n_q != 2'h0;
	assign unlocked = unlocked_q;
	assign cmd_mode = st_q == sfp_pkg::SFP_ST_CMD;

	// Reply and flow character transmitter
	sfp_tx u_tx (
		.core_clk(core_clk),
		.nrst(nrst),
		.start(tx_start_q),
		.msg(tx_msg_q),
		.code(tx_code_q),
		.flow_req(xoff || xon),
		.flow_chr(xoff ? `SFP_CH_DC3 : `SFP_CH_DC1),
		.hold(host_pause_q),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_locked_req;
		exec && known && gated && !unlocked_q;
	endsequence
	a_sync_reply: assert property (st_q == sfp_pkg::SFP_ST_WAIT && ch && rx_data == `SFP_CH_QM |=> tx_start_q && tx_msg_q == sfp_pkg::SFP_MSG_SYNC && st_q == sfp_pkg::SFP_ST_ECHO) // [R2]
		else $error("no sync text after question mark");
	a_freq_ok: assert property (st_q == sfp_pkg::SFP_ST_FREQ && ch && is_eol && fdig_q |=> tx_start_q && tx_msg_q == sfp_pkg::SFP_MSG_OK && cmd_mode) // [R3]
		else $error("frequency line not answered OK");
	a_echo_fail: assert property (st_q == sfp_pkg::SFP_ST_ECHO && ch && !esc_abort && rx_data != sfp_pkg::sfp_msg_char(sfp_pkg::SFP_MSG_SYNC, eidx_q, 8'h00) |=> st_q == sfp_pkg::SFP_ST_WAIT && !tx_start_q) // [R4]
		else $error("bad echo did not restart sync");
	a_locked_code: assert property (s_locked_req |=> tx_start_q && tx_code_q == `SFP_RC_LOCKED) // [R5]
		else $error("locked command not refused");
	a_locked_still: assert property (s_locked_req |=> !op_valid_q && cmd_mode [*2]) // [R20]
		else $error("locked command changed state");
	a_unknown_cmd: assert property (exec && !known |=> tx_start_q && tx_code_q == `SFP_RC_UNKNOWN) // [R6]
		else $error("unknown command code missing");
	a_eol_dropped: assert property (st_q == sfp_pkg::SFP_ST_CMD && ch && is_eol && !have_cmd_q |=> !tx_start_q && cmd_mode) // [R8]
		else $error("empty line produced a reply");
	a_line_limit: assert property (lchar_q <= `SFP_LINE_MAX) // [R12]
		else $error("encoded line too long");
	a_block_sum: assert property (st_q == sfp_pkg::SFP_ST_DATA && ch && is_eol && lchar_q != 6'h0 && lines_q == 5'h13 |=> st_q == sfp_pkg::SFP_ST_SUM) // [R13]
		else $error("no checksum after twenty lines");
	a_sum_answer: assert property (st_q == sfp_pkg::SFP_ST_SUM && ch && is_eol && innum_q |=> tx_start_q && (tx_msg_q == (($past(p0) == $past(sum_q)) ? sfp_pkg::SFP_MSG_OK : sfp_pkg::SFP_MSG_RESEND))) // [R14]
		else $error("checksum answer wrong");
	a_esc_abort: assert property (esc_abort |=> cmd_mode && !have_cmd_q && !fl_wr_valid) // [R17]
		else $error("escape did not abort");
	a_erase_sector: assert property (fl_op_valid && fl_op.kind == sfp_pkg::SFP_OP_ERASE |-> fl_op.addr == {17'h0_0000, fl_op.first, 12'h000}) // [R18]
		else $error("erase address not sector aligned");
	a_boot_go: assert property (exec && unlocked_q && cmd_q == "G" && in_boot(p0) |=> !op_valid_q && tx_code_q == `SFP_RC_PROT) // [R19]
		else $error("go into boot block accepted");
endmodule
`default_nettype wire

// file: verification/sfp_host_model.sv
// Host-side serial model that takes reply characters at a steady or slow pace
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [1:0] pace_q;
	logic [7:0] got[$];
	// ----------------------------------------
	// Pacing and capture
	// ----------------------------------------
	// Slow mode takes one character in four, like a busy serial line
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pace_q <= 2'h0;
		else
			pace_q <= pace_q + 2'h1;
	end
	assign tx_ready = slow ? (pace_q == 2'h3) : 1'b1;
	// Every character taken is kept for the bench to judge
	always @(posedge core_clk)
	begin
		if (nrst && tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule
`default_nettype wire

// file: verification/sfp_interp_tb.sv
// Self-checking bench for the serial flash programming interpreter
`timescale 1ns/1ps
`default_nettype none
module sfp_interp_tb;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic fl_wr_ready = 1'b1;
	logic slow = 1'b0;
	logic tx_valid, tx_ready, fl_op_valid, fl_wr_valid, unlocked, cmd_mode;
	logic [7:0] tx_data;
	sfp_pkg::sfp_op_t fl_op;
	sfp_pkg::sfp_wr_t fl_wr;
	sfp_pkg::sfp_op_t last_op;
	int n_errors = 0;
	int comparisons = 0;
	int n_ops = 0;
	logic [7:0] wr_d[$];
	logic [31:0] wr_a[$];
	string ungated[8] = '{"B 9600 1", "A 0", "R 0 4", "P 0 0", "I 0 0", "J", "K", "M 0 4 4"};

	always #12.5 core_clk = ~core_clk;

	sfp_interp uut (.core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .fl_op(fl_op),
		.fl_op_valid(fl_op_valid), .fl_wr(fl_wr), .fl_wr_valid(fl_wr_valid), .fl_wr_ready(fl_wr_ready),
		.unlocked(unlocked), .cmd_mode(cmd_mode));
	sfp_host_model host (.core_clk(core_clk), .nrst(nrst), .slow(slow), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));

	// Records flash operations and payload bytes as the flash side takes them
	always @(posedge core_clk)
	begin
		if (fl_op_valid === 1'b1)
		begin
			n_ops++;
			last_op = fl_op;
		end
		if (fl_wr_valid === 1'b1 && fl_wr_ready)
		begin
			wr_d.push_back(fl_wr.data);
			wr_a.push_back(fl_wr.addr);
		end
	end
	// ----------------------------------------
	// Stimulus helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic send_ch(input logic [7:0] c);
		rx_valid = 1'b1;
		rx_data = c;
		@(negedge core_clk);
		rx_valid = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic send_line(input string s);
		host.got.delete();
		foreach (s[i])
			send_ch(s[i]);
		send_ch(8'h0D);
	endtask
	// Bounded wait for n reply characters or for one given character
	task automatic wait_for(input int n, input logic [7:0] c, input bit by_char);
		int k;
		k = 0;
		while ((by_char ? !(c inside {host.got}) : host.got.size() < n) && k < 3000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (k == 3000)
		begin
			chk("reply wait", 32'h0, 32'h1);
			give_verdict();
		end
	endtask
	task automatic expect_reply(input string s);
		wait_for(s.len(), 8'h00, 1'b0);
		repeat (20) @(negedge core_clk);
		chk("reply length", s.len(), host.got.size());
		foreach (s[i])
			chk("reply char", s[i], host.got[i]);
	endtask
	task automatic rc(input string line, input string code);
		send_line(line);
		expect_reply({code, "\015\012"});
	endtask
	task automatic silent();
		repeat (40) @(negedge core_clk);
		chk("no reply", 32'h0, host.got.size());
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_bad_sync();
		host.got.delete();
		send_ch(8'h3F);
		expect_reply("Synchronized\015\012");
		send_line("Synchronizex");
		send_line("J");
		silent();
		chk("cmd_mode", 32'h0, {31'h0, cmd_mode});
	endtask
	task automatic t_sync();
		host.got.delete();
		send_ch(8'h3F);
		expect_reply("Synchronized\015\012");
		send_line("Synchronized");
		send_ch(8'h0A);
		expect_reply("OK\015\012");
		rc("10000", "OK");
		chk("cmd_mode", 32'h1, {31'h0, cmd_mode});
		host.got.delete();
		send_ch(8'h0D);
		send_ch(8'h0A);
		send_ch(8'h0A);
		silent();
	endtask
	task automatic t_locked();
		slow = 1'b1;
		rc("E 0 0", "3");
		rc("G 0 0", "3");
		rc("W 0 3", "3");
		rc("C 0 0 4", "3");
		chk("op count", 32'h0, n_ops);
		foreach (ungated[i])
			rc(ungated[i], "0");
		rc("X 1", "1");
		send_ch(8'h13);
		send_line("J");
		silent();
		send_ch(8'h11);
		expect_reply("0\015\012");
		chk("unlocked", 32'h0, {31'h0, unlocked});
		slow = 1'b0;
	endtask
	task automatic t_unlock();
		rc("U 1", "5");
		rc("U 23130", "0");
		chk("unlocked", 32'h1, {31'h0, unlocked});
		rc("E 2 3", "0");
		chk("op count", 32'h1, n_ops);
		chk("op addr", 32'h0000_2000, last_op.addr);
		chk("op sectors", 32'h13, {26'h0, last_op.first, last_op.last});
		chk("op kind", 32'h1, {30'h0, last_op.kind});
		rc("E 3 8", "2");
		rc("E 3 2", "2");
		rc("G 2147475456 0", "4");
		rc("W 2147483644 4", "4");
		rc("C 2147475456 0 4", "4");
		rc("W 16 0", "2");
		rc("C 8192 0 4", "0");
		chk("op count", 32'h1, n_ops);
		rc("G 256 0", "0");
		chk("op kind", 32'h2, {30'h0, last_op.kind});
		chk("op addr", 32'h0000_0100, last_op.addr);
		host.got.delete();
		send_ch(8'h45);
		send_ch(8'h20);
		send_ch(8'h31);
		send_ch(8'h1B);
		send_ch(8'h0D);
		silent();
		chk("op count", 32'h2, n_ops);
		rc("J", "0");
	endtask
	task automatic t_write();
		rc("W 16 3", "0");
		fl_wr_ready = 1'b0;
		send_line("#04)#");
		wait_for(0, 8'h13, 1'b1);
		fl_wr_ready = 1'b1;
		wait_for(0, 8'h11, 1'b1);
		chk("wr count", 32'h3, wr_d.size());
		rc("5", "RESEND");
		send_line("#04)#");
		repeat (20) @(negedge core_clk);
		rc("198", "OK");
		chk("wr count", 32'h6, wr_d.size());
		for (int k = 0; k < 6; k++)
		begin
			chk("wr data", 32'h41 + k % 3, wr_d[k]);
			chk("wr addr", 32'h10 + k % 3, wr_a[k]);
		end
		rc("W 4096 63", "0");
		for (int k = 0; k < 20; k++)
			send_line("#04)#");
		rc("3960", "OK");
		send_line("#04)#");
		rc("198", "OK");
		chk("wr count", 32'h45, wr_d.size());
		chk("cmd_mode", 32'h1, {31'h0, cmd_mode});
		rc("W 0 3", "0");
		rc("N", "2");
		rc("J", "0");
	endtask

	// Main sequence: reset for eight cycles, then every scenario in turn
	initial
	begin
		repeat (8) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		t_bad_sync();
		t_sync();
		t_locked();
		t_unlock();
		t_write();
		give_verdict();
	end
endmodule
`default_nettype wire
